// >>> common/irq_unit_pkg.sv
// Constants for the four-level interrupt response unit.
// Assumes an 8-bit register port with byte offsets as printed.
package irq_unit_pkg;
  // Register offsets
  localparam logic [7:0] TimerCtlOffset = 8'h88;
  localparam logic [7:0] EnableOffset = 8'ha8;
  localparam logic [7:0] PrioHighBasicOffset = 8'hb7;
  localparam logic [7:0] PrioLowBasicOffset = 8'hb8;
  localparam logic [7:0] ExtEnableOffset = 8'he8;
  localparam logic [7:0] PrioHighExtOffset = 8'hf7;
  localparam logic [7:0] PrioLowExtOffset = 8'hff;
  // Reset values
  localparam logic [7:0] RegResetValue = 8'h00;
  // Writable bits of the extended registers; reserved bits stay zero
  localparam logic [7:0] ExtEnableWritable = 8'hf7;
  localparam logic [7:0] ExtPrioWritable = 8'hf3;
  // Basic enable bit positions
  localparam int GlobalGateBit = 7;
  localparam int ConverterBit = 6;
  localparam int BrownoutBit = 5;
  localparam int SerialBit = 4;
  localparam int Timer1Bit = 3;
  localparam int Pin1Bit = 2;
  localparam int Timer0Bit = 1;
  localparam int Pin0Bit = 0;
  // Extended enable bit positions
  localparam int Timer2Bit = 7;
  localparam int SpiBit = 6;
  localparam int BrakeBit = 5;
  localparam int WatchdogBit = 4;
  localparam int CaptureEnBit = 2;
  localparam int KeypadBit = 1;
  localparam int I2cBit = 0;
  // Capture priority sits in basic priority registers
  localparam int CapturePrioBit = 7;
  // Timer control bit positions
  localparam int Tmr1FlagBit = 7;
  localparam int Tmr0FlagBit = 5;
  localparam int Pin1FlagBit = 3;
  localparam int Pin1TypeBit = 2;
  localparam int Pin0FlagBit = 1;
  localparam int Pin0TypeBit = 0;
  // Timing
  localparam int ClocksPerMachineCycle = 4;
  localparam int SamplePhase = 2;
  localparam int VectorCallMachineCycles = 4;
  localparam int RegAccessMachineCycles = 3;
  localparam int MulDivMachineCycles = 5;
  localparam int MinLatencyMachineCycles = 5;
  localparam int MaxLatencyMachineCycles = 12;
  localparam int MaxLatencyClocks = MaxLatencyMachineCycles * ClocksPerMachineCycle;
  // Number of sources, indexed by arbitration rank (0 = highest)
  localparam int NumSources = 14;
  localparam logic [3:0] NoSource = 4'hf;
endpackage : irq_unit_pkg

// >>> verilog/pin_edge_sync.sv
// Three-stage synchroniser and falling-edge detect for one pin.
// Assumes an asynchronous, idle-high pin.
`timescale 1ns/10ps
module pin_edge_sync (
  // Clock and control
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEnable,
  // Pin
  input wire logic pinAsync,
  // Results
  output logic pinLevel,
  output logic pinFell
);
  logic [2:0] stage_reg;
  logic level_reg;

  // Stage 0 feeds only stage 1
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage_reg <= 3'b111;
      level_reg <= 1'b1;
    end else if (clkEnable) begin
      stage_reg <= {stage_reg[1:0], pinAsync};
      if (stage_reg[1] == stage_reg[2]) begin
        level_reg <= stage_reg[2];
      end
    end
  end

  assign pinLevel = level_reg;
  assign pinFell = level_reg & (stage_reg[1] == stage_reg[2]) & ~stage_reg[2];
endmodule : pin_edge_sync

// >>> verilog/irq_response_unit.sv
// Four-level interrupt response unit: masking, priority, vector call timing.
// Assumes a core that flags instruction ends; peripheral flags on sys_clk.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps

// Overview of operation
// - Sample pins and serial requests at phase three
// - Timer overflow flags polled next machine cycle
// - Vector call lasts exactly four machine cycles
// - Single-source latency five to twelve cycles
// - Postpone on busy level or mid-instruction
// - Mask register write blocks through next instruction
// - Machine cycle equals four system clocks
// - Global gate bit seven disables all
// - Bit four gates serial transmit or receive
// - Bits three, one, six, five gate sources
// - Bits two and zero gate pins
// - Extended enable bit map, bit three reserved
// - High priority bit forms level upper bit
// - Low priority bit forms level lower bit
// - Extended priority bit map, bits 3:2 reserved
// - Capture priority at basic bit seven
// - Edge flag sticky, level flag inverts pin
// - Type bit: zero level, one falling edge
// - Pin flags and types in timer control
// - Two bits encode levels, strictly higher preempts
// - Vector only when all three conditions hold
// - Fixed ranking breaks ties within level
// - Hardware clears timer flags on vector
module irq_response_unit #(
  parameter int SOURCES = irq_unit_pkg::NumSources
) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEnable,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // External pins, active low
  input wire logic external_pin_zero,
  input wire logic external_pin_one,
  // Peripheral request flags
  input wire logic timer0Overflow,
  input wire logic timer1Overflow,
  input wire logic serial_tx_done_flag,
  input wire logic serial_rx_done_flag,
  input wire logic converterReq,
  input wire logic brownoutReq,
  input wire logic timer2Req,
  input wire logic spiReq,
  input wire logic brakeReq,
  input wire logic watchdogReq,
  input wire logic captureReq,
  input wire logic keypadReq,
  input wire logic i2cReq,
  // Core sequencer
  input wire logic instrLastCycle,
  input wire logic instrIsReturn,
  // Vector call to the core
  output logic vectorCallBusy,
  output logic vectorCallStart,
  output logic [3:0] vectorSource,
  output logic [1:0] activeLevelMask
);
  typedef enum logic [1:0] {IDLE, CALLING} call_state_e;

  // Registers
  logic [7:0] timerCtl_reg;
  logic [7:0] enable_reg;
  logic [7:0] prioHighBasic_reg;
  logic [7:0] prioLowBasic_reg;
  logic [7:0] extEnable_reg;
  logic [7:0] prioHighExt_reg;
  logic [7:0] prioLowExt_reg;
  logic [7:0] rdData_reg;

  // Timing state
  logic [1:0] phase_reg;
  logic [3:0] callCount_reg;
  call_state_e state_reg;
  call_state_e state_next;
  logic [3:0] inService_reg;
  logic [1:0] guard_reg;
  logic [1:0] polledTimers_reg;
  logic serialSample_reg;
  logic [3:0] source_reg;
  logic callStart_reg;
  logic [1:0] topLevel_reg;

  // Pin sync
  logic pin0Level;
  logic pin0Fell;
  logic pin1Level;
  logic pin1Fell;

  pin_edge_sync pin0Sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .clkEnable(clkEnable),
    .pinAsync(external_pin_zero),
    .pinLevel(pin0Level),
    .pinFell(pin0Fell)
  );

  pin_edge_sync pin1Sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .clkEnable(clkEnable),
    .pinAsync(external_pin_one),
    .pinLevel(pin1Level),
    .pinFell(pin1Fell)
  );

  // Four clocks per machine cycle
  wire phaseThree = (phase_reg == 2'(irq_unit_pkg::SamplePhase));
  wire machineEnd = (phase_reg == 2'(irq_unit_pkg::ClocksPerMachineCycle - 1));

  // Register decode
  wire hitTimerCtl = (regAddr == irq_unit_pkg::TimerCtlOffset);
  wire hitEnable = (regAddr == irq_unit_pkg::EnableOffset);
  wire hitPrioHighBasic = (regAddr == irq_unit_pkg::PrioHighBasicOffset);
  wire hitPrioLowBasic = (regAddr == irq_unit_pkg::PrioLowBasicOffset);
  wire hitExtEnable = (regAddr == irq_unit_pkg::ExtEnableOffset);
  wire hitPrioHighExt = (regAddr == irq_unit_pkg::PrioHighExtOffset);
  wire hitPrioLowExt = (regAddr == irq_unit_pkg::PrioLowExtOffset);
  wire maskWrite = regWrite & (hitEnable | hitPrioHighBasic | hitPrioLowBasic
                   | hitExtEnable | hitPrioHighExt | hitPrioLowExt);

  wire [7:0] rdMux = hitTimerCtl ? timerCtl_reg :
                     hitEnable ? enable_reg :
                     hitPrioHighBasic ? prioHighBasic_reg :
                     hitPrioLowBasic ? prioLowBasic_reg :
                     hitExtEnable ? extEnable_reg :
                     hitPrioHighExt ? prioHighExt_reg :
                     hitPrioLowExt ? prioLowExt_reg : 8'h00;

  // Requests in arbitration order, index 0 highest
  wire [SOURCES-1:0] pending;
  wire [SOURCES-1:0] enables;
  wire [SOURCES-1:0] prioHigh;
  wire [SOURCES-1:0] prioLow;

  assign pending = {captureReq, timer2Req, spiReq, brakeReq, serialSample_reg, polledTimers_reg[1],
                    keypadReq, timerCtl_reg[irq_unit_pkg::Pin1FlagBit], converterReq, i2cReq,
                    polledTimers_reg[0], watchdogReq, brownoutReq,
                    timerCtl_reg[irq_unit_pkg::Pin0FlagBit]};
  assign enables = {extEnable_reg[irq_unit_pkg::CaptureEnBit],
                    extEnable_reg[irq_unit_pkg::Timer2Bit], extEnable_reg[irq_unit_pkg::SpiBit],
                    extEnable_reg[irq_unit_pkg::BrakeBit],
                    enable_reg[irq_unit_pkg::SerialBit],
                    enable_reg[irq_unit_pkg::Timer1Bit],
                    extEnable_reg[irq_unit_pkg::KeypadBit],
                    enable_reg[irq_unit_pkg::Pin1Bit],
                    enable_reg[irq_unit_pkg::ConverterBit], extEnable_reg[irq_unit_pkg::I2cBit],
                    enable_reg[irq_unit_pkg::Timer0Bit], extEnable_reg[irq_unit_pkg::WatchdogBit],
                    enable_reg[irq_unit_pkg::BrownoutBit], enable_reg[irq_unit_pkg::Pin0Bit]};
  assign prioHigh = {prioHighBasic_reg[irq_unit_pkg::CapturePrioBit],
                     prioHighExt_reg[7:5], prioHighBasic_reg[4:3], prioHighExt_reg[1],
                     prioHighBasic_reg[2], prioHighBasic_reg[6], prioHighExt_reg[0],
                     prioHighBasic_reg[1], prioHighExt_reg[4], prioHighBasic_reg[5],
                     prioHighBasic_reg[0]};
  assign prioLow = {prioLowBasic_reg[irq_unit_pkg::CapturePrioBit],
                    prioLowExt_reg[7:5], prioLowBasic_reg[4:3], prioLowExt_reg[1],
                    prioLowBasic_reg[2], prioLowBasic_reg[6], prioLowExt_reg[0],
                    prioLowBasic_reg[1], prioLowExt_reg[4], prioLowBasic_reg[5],
                    prioLowBasic_reg[0]};

  wire [SOURCES-1:0] live = pending & enables & {SOURCES{enable_reg[irq_unit_pkg::GlobalGateBit]}};

  // Highest level first, then lowest rank
  function automatic logic [3:0] pick(input logic [SOURCES-1:0] req, input logic [SOURCES-1:0] hi,
                                      input logic [SOURCES-1:0] lo, output logic [1:0] lvl);
    logic [3:0] best;
    logic [1:0] bestLvl;
    best = irq_unit_pkg::NoSource;
    bestLvl = 2'd0;
    for (int i = SOURCES - 1; i >= 0; i--) begin
      if (req[i] && ({hi[i], lo[i]} >= bestLvl || best == irq_unit_pkg::NoSource)) begin
        best = 4'(i);
        bestLvl = {hi[i], lo[i]};
      end
    end
    lvl = bestLvl;
    return best;
  endfunction : pick

  logic [1:0] winLevel;
  logic [3:0] winner;
  always_comb begin
    winner = pick(live, prioHigh, prioLow, winLevel);
  end

  // Highest level in service
  wire [1:0] busyLevel = inService_reg[3] ? 2'd3 : inService_reg[2] ? 2'd2 :
                         inService_reg[1] ? 2'd1 : 2'd0;
  wire levelFree = (inService_reg == 4'h0) || (winLevel > busyLevel);
  wire accept = (state_reg == IDLE) && machineEnd && (winner != irq_unit_pkg::NoSource)
                && levelFree && instrLastCycle && !instrIsReturn && (guard_reg == 2'd0);
  wire callDone = (state_reg == CALLING) && machineEnd
                  && (callCount_reg == 4'(irq_unit_pkg::VectorCallMachineCycles - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      IDLE: if (accept) state_next = CALLING;
      CALLING: if (callDone) state_next = IDLE;
    endcase
  end

  // Return clears the top level
  wire [3:0] topBit = inService_reg[3] ? 4'b1000 : inService_reg[2] ? 4'b0100 :
                      inService_reg[1] ? 4'b0010 : inService_reg[0] ? 4'b0001 : 4'b0000;
  wire [3:0] levelBit = 4'b0001 << winLevel;

  // Hardware clears on vector
  wire clearPin0 = accept && winner == 4'd0;
  wire clearTmr0 = accept && winner == 4'd3;
  wire clearPin1 = accept && winner == 4'd6;
  wire clearTmr1 = accept && winner == 4'd8;

  // External flag next values
  wire pin0Next = timerCtl_reg[irq_unit_pkg::Pin0TypeBit] ?
                  (pin0Fell | (timerCtl_reg[irq_unit_pkg::Pin0FlagBit] & ~clearPin0)) : ~pin0Level;
  wire pin1Next = timerCtl_reg[irq_unit_pkg::Pin1TypeBit] ?
                  (pin1Fell | (timerCtl_reg[irq_unit_pkg::Pin1FlagBit] & ~clearPin1)) : ~pin1Level;

  wire [7:0] ctlBase = (regWrite && hitTimerCtl) ? regWrData : timerCtl_reg;
  logic [7:0] ctlNext;
  always_comb begin
    ctlNext = ctlBase;
    if (clearTmr0) ctlNext[irq_unit_pkg::Tmr0FlagBit] = 1'b0;
    if (clearTmr1) ctlNext[irq_unit_pkg::Tmr1FlagBit] = 1'b0;
    if (clearPin0) ctlNext[irq_unit_pkg::Pin0FlagBit] = 1'b0;
    if (clearPin1) ctlNext[irq_unit_pkg::Pin1FlagBit] = 1'b0;
    if (phaseThree) begin
      ctlNext[irq_unit_pkg::Pin0FlagBit] = (regWrite && hitTimerCtl && !regWrData[irq_unit_pkg::Pin0TypeBit])
                                           ? ~pin0Level : pin0Next | (regWrite && hitTimerCtl
                                           && regWrData[irq_unit_pkg::Pin0FlagBit]);
      ctlNext[irq_unit_pkg::Pin1FlagBit] = (regWrite && hitTimerCtl && !regWrData[irq_unit_pkg::Pin1TypeBit])
                                           ? ~pin1Level : pin1Next | (regWrite && hitTimerCtl
                                           && regWrData[irq_unit_pkg::Pin1FlagBit]);
      // Overflow set beats same-cycle clear
      if (timer0Overflow) ctlNext[irq_unit_pkg::Tmr0FlagBit] = 1'b1;
      if (timer1Overflow) ctlNext[irq_unit_pkg::Tmr1FlagBit] = 1'b1;
    end else begin
      // Edges between samples are kept
      if (pin0Fell && timerCtl_reg[irq_unit_pkg::Pin0TypeBit]) ctlNext[irq_unit_pkg::Pin0FlagBit] = 1'b1;
      if (pin1Fell && timerCtl_reg[irq_unit_pkg::Pin1TypeBit]) ctlNext[irq_unit_pkg::Pin1FlagBit] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timerCtl_reg <= irq_unit_pkg::RegResetValue;
      enable_reg <= irq_unit_pkg::RegResetValue;
      prioHighBasic_reg <= irq_unit_pkg::RegResetValue;
      prioLowBasic_reg <= irq_unit_pkg::RegResetValue;
      extEnable_reg <= irq_unit_pkg::RegResetValue;
      prioHighExt_reg <= irq_unit_pkg::RegResetValue;
      prioLowExt_reg <= irq_unit_pkg::RegResetValue;
      rdData_reg <= 8'h00;
    end else if (clkEnable) begin
      timerCtl_reg <= ctlNext;
      if (regWrite && hitEnable) enable_reg <= regWrData;
      if (regWrite && hitPrioHighBasic) prioHighBasic_reg <= regWrData;
      if (regWrite && hitPrioLowBasic) prioLowBasic_reg <= regWrData;
      if (regWrite && hitExtEnable) extEnable_reg <= regWrData & irq_unit_pkg::ExtEnableWritable;
      if (regWrite && hitPrioHighExt) prioHighExt_reg <= regWrData & irq_unit_pkg::ExtPrioWritable;
      if (regWrite && hitPrioLowExt) prioLowExt_reg <= regWrData & irq_unit_pkg::ExtPrioWritable;
      rdData_reg <= regRead ? rdMux : 8'h00;
    end
  end

  // Guard: 2 = write running, 1 = one instruction left
  logic [1:0] guardNext;
  always_comb begin
    guardNext = guard_reg;
    if (maskWrite) guardNext = 2'd2;
    else if (machineEnd && instrLastCycle && guard_reg != 2'd0) guardNext = guard_reg - 2'd1;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_reg <= 2'd0;
      state_reg <= IDLE;
      callCount_reg <= 4'd0;
      inService_reg <= 4'h0;
      guard_reg <= 2'd0;
      polledTimers_reg <= 2'b00;
      serialSample_reg <= 1'b0;
      source_reg <= irq_unit_pkg::NoSource;
      callStart_reg <= 1'b0;
      topLevel_reg <= 2'd0;
    end else if (clkEnable) begin
      phase_reg <= phase_reg + 2'd1;
      state_reg <= state_next;
      guard_reg <= guardNext;
      callStart_reg <= accept;
      topLevel_reg <= busyLevel;
      if (phaseThree) serialSample_reg <= serial_tx_done_flag | serial_rx_done_flag;
      // Flags polled one machine cycle after they set
      if (machineEnd) polledTimers_reg <= {timerCtl_reg[irq_unit_pkg::Tmr1FlagBit],
                                           timerCtl_reg[irq_unit_pkg::Tmr0FlagBit]};
      if (accept) begin
        source_reg <= winner;
        callCount_reg <= 4'd0;
        inService_reg <= inService_reg | levelBit;
      end else if (state_reg == CALLING && machineEnd) begin
        callCount_reg <= callCount_reg + 4'd1;
      end else if (state_reg == IDLE && instrIsReturn && machineEnd && instrLastCycle) begin
        inService_reg <= inService_reg & ~topBit;
      end
    end
  end

  assign regRdData = rdData_reg;
  assign vectorCallBusy = (state_reg == CALLING);
  assign vectorCallStart = callStart_reg;
  assign vectorSource = source_reg;
  assign activeLevelMask = topLevel_reg;
endmodule : irq_response_unit

// >>> bench/irq_response_unit_asserts.sv
// Port checks for the interrupt response unit.
// Assumes clkEnable held high.
`timescale 1ns/10ps
module irq_response_unit_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Core side
  input wire logic instrLastCycle,
  input wire logic instrIsReturn,
  input wire logic vectorCallBusy,
  input wire logic vectorCallStart,
  input wire logic [3:0] vectorSource
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [1:0] phase_reg;
  logic gate_reg;
  wire isExtEn = regAddr == irq_unit_pkg::ExtEnableOffset;
  wire isExtPrio = regAddr inside {irq_unit_pkg::PrioHighExtOffset, irq_unit_pkg::PrioLowExtOffset};
  wire isMapped = isExtEn || isExtPrio || regAddr inside {irq_unit_pkg::TimerCtlOffset, irq_unit_pkg::EnableOffset,
    irq_unit_pkg::PrioHighBasicOffset, irq_unit_pkg::PrioLowBasicOffset};
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_reg <= 2'h0;
      gate_reg <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (regWrite && regAddr == irq_unit_pkg::EnableOffset) gate_reg <= regWrData[7];
    end
  end
  sequence busyRun;
    vectorCallBusy [*8];
  endsequence
  a_call_length: assert property (vectorCallStart |-> busyRun ##1 busyRun ##1 !vectorCallBusy)
    else $error("call length");
  a_busy_cause: assert property ($rose(vectorCallBusy) |-> vectorCallStart)
    else $error("busy without start");
  a_instr_end: assert property (vectorCallStart |-> $past(instrLastCycle) && !$past(instrIsReturn))
    else $error("vector mid-instruction");
  a_machine_phase: assert property (vectorCallStart |-> phase_reg == 2'h0)
    else $error("vector off cycle edge");
  a_global_gate: assert property (vectorCallStart |-> $past(gate_reg))
    else $error("vector with gate off");
  a_rank_range: assert property (vectorCallStart |-> vectorSource <= 4'hd)
    else $error("bad source rank");
  a_read_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("stray read data");
  a_unmapped_zero: assert property ($past(regRead) && !$past(isMapped) |-> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_rsvd_enable: assert property ($past(regRead) && $past(isExtEn) |-> !regRdData[3])
    else $error("reserved enable bit");
  a_rsvd_prio: assert property ($past(regRead) && $past(isExtPrio) |-> regRdData[3:2] == 2'h0)
    else $error("reserved priority bits");
endmodule : irq_response_unit_asserts

bind irq_response_unit irq_response_unit_asserts i_irq_response_unit_asserts (
  .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .instrLastCycle(instrLastCycle), .instrIsReturn(instrIsReturn),
  .vectorCallBusy(vectorCallBusy), .vectorCallStart(vectorCallStart), .vectorSource(vectorSource)
);

// >>> bench/core_seq_model.sv
// Core sequencer stand-in: instructions of instrLen machine cycles.
// Assumes phase aligned with the unit at reset.
`timescale 1ns/10ps
module core_seq_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Bench control
  input wire logic [2:0] instrLen,
  input wire logic returnReq,
  // Unit side
  input wire logic vectorCallBusy,
  output logic instrLastCycle,
  output logic instrIsReturn
);
  logic [1:0] phase_reg;
  logic [2:0] mc_reg;
  logic pend_reg;
  // Stalls during vector call
  assign instrLastCycle = !vectorCallBusy && (mc_reg + 3'h1 >= instrLen);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_reg <= 2'h0;
      mc_reg <= 3'h0;
      pend_reg <= 1'b0;
      instrIsReturn <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == 2'h3 && instrLastCycle) begin
        mc_reg <= 3'h0;
        instrIsReturn <= pend_reg || returnReq;
        pend_reg <= 1'b0;
      end else begin
        if (phase_reg == 2'h3 && !vectorCallBusy) mc_reg <= mc_reg + 3'h1;
        if (returnReq) pend_reg <= 1'b1;
      end
    end
  end
endmodule : core_seq_model

// >>> bench/tb_top.sv
// Bench for the interrupt response unit.
// Assumes the core model; requests are bench levels.
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {
    logic [7:0] ie;
    logic [7:0] extended_irq_enable_mask;
    logic [7:0] ipl;
    logic [7:0] priority_high_basic;
    logic [7:0] priority_low_extended;
    logic [13:0] req;
    logic [3:0] src;
  } row_s;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [13:0] reqs = 14'h0000;
  logic [2:0] instrLen = 3'h1;
  logic returnReq = 1'b0;
  logic [7:0] regRdData;
  logic instrLastCycle, instrIsReturn, vectorCallBusy, vectorCallStart;
  logic [3:0] vectorSource;
  logic [1:0] activeLevelMask;
  logic [7:0] d;
  int failures = 0;
  int checked = 0;
  int cyc;
  logic [7:0] offs [8] = '{8'h88, 8'ha8, 8'hb7, 8'hb8, 8'he8, 8'hf7, 8'hff, 8'h90};
  // Request bits follow arbitration rank
  row_s rows [19] = '{
    '{8'h81,8'h00,8'h00,8'h00,8'h00,14'h0001,4'h0}, '{8'h84,8'h00,8'h00,8'h00,8'h00,14'h0040,4'h6},
    '{8'h82,8'h00,8'h00,8'h00,8'h00,14'h0008,4'h3}, '{8'h88,8'h00,8'h00,8'h00,8'h00,14'h0100,4'h8},
    '{8'h90,8'h00,8'h00,8'h00,8'h00,14'h0200,4'h9}, '{8'hc0,8'h00,8'h00,8'h00,8'h00,14'h0020,4'h5},
    '{8'ha0,8'h00,8'h00,8'h00,8'h00,14'h0002,4'h1}, '{8'h80,8'hf7,8'h00,8'h00,8'h00,14'h3c94,4'h2},
    '{8'h80,8'ha3,8'h00,8'h00,8'h00,14'h3c94,4'h4}, '{8'h80,8'h44,8'h00,8'h00,8'h00,14'h3c94,4'hb},
    '{8'h80,8'h04,8'h00,8'h00,8'h00,14'h2000,4'hd}, '{8'h7f,8'hf7,8'h00,8'h00,8'h00,14'h3fff,4'hf},
    '{8'hef,8'h00,8'h00,8'h00,8'h00,14'h0200,4'hf}, '{8'hff,8'hf7,8'h00,8'h00,8'h00,14'h3fff,4'h0},
    '{8'he0,8'h00,8'h40,8'h00,8'h00,14'h0022,4'h5}, '{8'he0,8'h00,8'h40,8'h20,8'h00,14'h0022,4'h1},
    '{8'ha0,8'h04,8'h80,8'h00,8'h00,14'h2002,4'hd}, '{8'h81,8'h80,8'h00,8'h00,8'h80,14'h1001,4'hc},
    '{8'h80,8'h22,8'h00,8'h00,8'h20,14'h0480,4'ha}};

  irq_response_unit i_irq_response_unit (
    .sys_clk(sys_clk), .reset(reset), .clkEnable(1'b1), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .external_pin_zero(!reqs[0]),
    .external_pin_one(!reqs[6]), .timer0Overflow(reqs[3]), .timer1Overflow(reqs[8]),
    .serial_tx_done_flag(reqs[9]), .serial_rx_done_flag(1'b0), .converterReq(reqs[5]), .brownoutReq(reqs[1]),
    .timer2Req(reqs[12]), .spiReq(reqs[11]), .brakeReq(reqs[10]), .watchdogReq(reqs[2]),
    .captureReq(reqs[13]), .keypadReq(reqs[7]), .i2cReq(reqs[4]), .instrLastCycle(instrLastCycle),
    .instrIsReturn(instrIsReturn), .vectorCallBusy(vectorCallBusy), .vectorCallStart(vectorCallStart),
    .vectorSource(vectorSource), .activeLevelMask(activeLevelMask));
  core_seq_model i_core_seq_model (
    .sys_clk(sys_clk), .reset(reset), .instrLen(instrLen), .returnReq(returnReq),
    .vectorCallBusy(vectorCallBusy), .instrLastCycle(instrLastCycle), .instrIsReturn(instrIsReturn));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic give_up;
    failures++;
    end_of_test();
  endtask : give_up
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask : rd
  // Steps past the current edge: no stale start pulse
  task automatic wait_start(input int bound, input logic must);
    cyc = 0;
    do begin
      @(posedge sys_clk);
      #1 cyc++;
    end while (vectorCallStart !== 1'b1 && cyc < bound);
    if (must && vectorCallStart !== 1'b1) give_up();
  endtask : wait_start
  task automatic retire;
    int i;
    @(posedge sys_clk);
    returnReq <= 1'b1;
    @(posedge sys_clk);
    returnReq <= 1'b0;
    for (i = 0; i < 200 && instrIsReturn !== 1'b1; i++) @(posedge sys_clk);
    for (i = 0; i < 200 && instrIsReturn === 1'b1; i++) #8;
    if (i == 200) give_up();
  endtask : retire

  initial forever #4 sys_clk = ~sys_clk;
  initial begin
    repeat (100000) @(posedge sys_clk);
    give_up();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (rows[r]) begin
      wr(irq_unit_pkg::TimerCtlOffset, 8'h00);
      wr(irq_unit_pkg::EnableOffset, 8'h00);
      retire();
      wr(irq_unit_pkg::ExtEnableOffset, rows[r].extended_irq_enable_mask);
      wr(irq_unit_pkg::PrioLowBasicOffset, rows[r].ipl);
      wr(irq_unit_pkg::PrioHighBasicOffset, rows[r].priority_high_basic);
      wr(irq_unit_pkg::PrioLowExtOffset, rows[r].priority_low_extended);
      wr(irq_unit_pkg::EnableOffset, rows[r].ie);
      @(posedge sys_clk);
      reqs <= rows[r].req;
      wait_start(100, rows[r].src != 4'hf);
      check("source", {4'h0, (vectorCallStart === 1'b1) ? vectorSource : 4'hf}, {4'h0, rows[r].src});
      @(posedge sys_clk);
      reqs <= 14'h0000;
      if (rows[r].src == 4'h3 || rows[r].src == 4'h8) begin
        rd(irq_unit_pkg::TimerCtlOffset);
        check("timer flags", d & 8'ha0, 8'h00);
      end
    end
    // Mid-run reset, reset values, a hole
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (offs[i]) begin
      rd(offs[i]);
      check("reset value", d, 8'h00);
    end
    wr(irq_unit_pkg::ExtEnableOffset, 8'hff);
    wr(irq_unit_pkg::PrioHighExtOffset, 8'hff);
    wr(irq_unit_pkg::PrioLowExtOffset, 8'hff);
    rd(irq_unit_pkg::ExtEnableOffset);
    check("ext enable", d, 8'hf7);
    rd(irq_unit_pkg::PrioHighExtOffset);
    check("ext prio high", d, 8'hf3);
    rd(irq_unit_pkg::PrioLowExtOffset);
    check("ext prio low", d, 8'hf3);
    // Pin zero edge, pin one level
    wr(irq_unit_pkg::TimerCtlOffset, 8'h01);
    @(posedge sys_clk);
    reqs <= 14'h0041;
    repeat (8) @(posedge sys_clk);
    reqs <= 14'h0040;
    repeat (8) @(posedge sys_clk);
    rd(irq_unit_pkg::TimerCtlOffset);
    check("pin flags", d, 8'h0b);
    @(posedge sys_clk);
    reqs <= 14'h0000;
    wr(irq_unit_pkg::EnableOffset, 8'h81);
    wait_start(100, 1'b1);
    check("edge source", {4'h0, vectorSource}, 8'h00);
    rd(irq_unit_pkg::TimerCtlOffset);
    check("edge flag", d, 8'h01);
    // Latency, one-cycle instructions
    retire();
    wr(irq_unit_pkg::EnableOffset, 8'hc0);
    repeat (16) @(posedge sys_clk);
    reqs <= 14'h0020;
    wait_start(60, 1'b1);
    check("latency", {7'h0, cyc + 16 <= irq_unit_pkg::MaxLatencyClocks}, 8'h01);
    // Write guard, five-cycle instructions
    @(posedge sys_clk);
    reqs <= 14'h0000;
    wr(irq_unit_pkg::EnableOffset, 8'h40);
    retire();
    instrLen <= 3'h5;
    reqs <= 14'h0020;
    wr(irq_unit_pkg::EnableOffset, 8'he0);
    wait_start(120, 1'b1);
    check("write guard", {7'h0, cyc >= 16}, 8'h01);
    // Equal level waits, higher preempts
    @(posedge sys_clk);
    reqs <= 14'h0022;
    wait_start(60, 1'b0);
    check("equal level", {4'h0, (vectorCallStart === 1'b1) ? vectorSource : 4'hf}, 8'h0f);
    wr(irq_unit_pkg::PrioHighBasicOffset, 8'h20);
    wait_start(120, 1'b1);
    check("preempt source", {4'h0, vectorSource}, 8'h01);
    @(posedge sys_clk);
    #1 check("active level", {6'h0, activeLevelMask}, 8'h02);
    end_of_test();
  end
endmodule : tb_top
